// ===== cssp_pkg.sv
// package: constants for core stack, scratch-pad and power control block
package cssp_pkg;
  // register indices; the byte address on the bus is four times the index
  localparam logic [7:0] CSSP_IDX_PULLUP = 8'h86;
  localparam logic [7:0] CSSP_IDX_PWR = 8'h87;
  localparam logic [7:0] CSSP_IDX_SP = 8'h81;
  localparam logic [7:0] CSSP_IDX_FLAGS = 8'hD0;
  localparam logic [7:0] CSSP_IDX_B = 8'hF0;
  localparam logic [7:0] CSSP_IDX_SERIAL_CONTROL_REGISTER = 8'h98;
  localparam logic [7:0] CSSP_IDX_STAT = 8'h40;
  localparam logic [7:0] CSSP_IDX_CORE = 8'h41;
  localparam logic [11:0] CSSP_RAM_BASE = 12'h400;
  // field positions and power control write mask
  localparam int CSSP_PWR_BAUD = 7;
  localparam int CSSP_PWR_FCS = 6;
  localparam int CSSP_PWR_RSVD = 5;
  localparam int CSSP_PWR_POR = 4;
  localparam int CSSP_PWR_PD = 1;
  localparam int CSSP_PWR_IDL = 0;
  localparam logic [7:0] CSSP_PWR_WMASK = 8'hDF;
  // reset values and bit-addressable ram range
  localparam logic [7:0] CSSP_SP_RESET = 8'h07;
  localparam logic [7:0] CSSP_PWR_RESET = 8'h10;
  localparam logic [7:0] CSSP_BYTE_ZERO = 8'h00;
  localparam logic [7:0] CSSP_BITRAM_LO = 8'h20;
  localparam logic [7:0] CSSP_BITRAM_HI = 8'h2F;
  // clocks per machine cycle
  localparam logic [3:0] CSSP_CLK_12T = 4'hC;
  localparam logic [3:0] CSSP_CLK_6T = 4'h6;
  // axi response codes
  localparam logic [1:0] CSSP_RESP_OKAY = 2'h0;
  localparam logic [1:0] CSSP_RESP_SLVERR = 2'h2;
  // core operation codes
  typedef enum logic [2:0] {
    CSSP_OP_NONE,
    CSSP_OP_PUSH,
    CSSP_OP_POP,
    CSSP_OP_CALL,
    CSSP_OP_BITSET,
    CSSP_OP_BITCLR
  } cssp_op_type;
endpackage : cssp_pkg

// ===== cssp_cycle_div.sv
// machine cycle divider: one-cycle tick every 12 or 6 input clocks
`timescale 1ns/1ps
module cssp_cycle_div (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic six_clk_mode,
  input wire logic run,
  output logic tick
);
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  wire logic [3:0] period = six_clk_mode ? cssp_pkg::CSSP_CLK_6T : cssp_pkg::CSSP_CLK_12T;
  wire logic wrap = (cnt_r == period - 4'h1) || (cnt_r >= period);
  assign cnt_nxt = !run ? cnt_r : (wrap ? 4'h0 : cnt_r + 4'h1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 4'h0;
      tick <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick <= run && wrap;
    end
  end
endmodule : cssp_cycle_div

// ===== cssp_core.sv
// core scratch-pad ram, stack pointer, sfr bits and power control
//
// Operation
// - machine cycle is twelve clocks, or six when the strap selects it.
// - 256-byte scratch-pad ram for software storage.
// - ram bytes 20h to 2Fh are also bit addressable.
// - sfrs at addresses ending 0 or 8 allow bit access; only B (F0h) and alu flags (D0h) are bit-written here.
// - bit or byte access chosen by instruction type alone.
// - stack pointer resets to 07h, software may load any value.
// - push increments pointer first, then writes at new address.
// - pop reads at pointer first, then decrements it.
// - call or interrupt saves return address on the stack.
// - stack lives only in scratch-pad ram, depth bounded by it.
// - second operand register feeds multiply/divide, else general purpose.
// - alu status bits are written into the alu flags register.
// - pull-up bit 0 clear means open-drain, set means pulled up.
// - baud doubler bit 7 doubles serial rate in modes 1-3.
// - frame check select makes serial top bit a frame error flag.
// - power-on flag set by power-on reset, cleared by software.
// - power-down bit stops all clocks and freezes execution.
// - cpu halt bit stops only the cpu clock.
// - power control bits 3 and 2 are plain user flags.
// - enabled interrupt in idle clears halt bit and resumes.
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module cssp_core #(
  parameter int RAM_DEPTH = 256
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic por_event,
  input wire logic six_clk_strap,
  input wire logic irq_pending,
  input wire logic wake_event,
  input wire logic [7:0] alu_flags_in,
  input wire logic alu_flags_we,
  input wire logic frame_error_flag,
  input wire logic [2:0] core_op,
  input wire logic [7:0] core_addr,
  input wire logic [2:0] core_bit,
  input wire logic [15:0] return_addr,
  input wire logic [7:0] core_wdata,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [7:0] core_rdata,
  output logic core_done,
  output logic machine_tick,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic port0_pullup_select,
  output logic baud_doubler,
  output logic serial_mode_top_bit,
  output logic [7:0] b_operand
);
  // state
  logic [7:0] ram_r [RAM_DEPTH];
  logic [7:0] stack_top_pointer_r;
  logic [7:0] power_control_r;
  logic [7:0] port0_pullup_ctrl_r;
  logic [7:0] alu_flags_register_r;
  logic [7:0] b_reg_r;
  logic serial_control_register_top_r;
  logic [7:0] op_cnt_r;
  logic six_mode_r;
  logic strap_caught_r;
  logic [2:0] por_sync_r;
  logic [2:0] wake_sync_r;
  logic call_hi_r;
  cssp_pkg::cssp_op_type op_r;

  // axi handshake state
  logic aw_held_r;
  logic w_held_r;
  logic [31:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;

  // pin inputs pass three flops; change counts once stages 2 and 3 agree
  logic por_seen_r;
  logic wake_seen_r;
  wire logic por_pulse = por_sync_r[1] && por_sync_r[2] && !por_seen_r;
  wire logic wake_lvl = wake_sync_r[1] && wake_sync_r[2];

  wire logic halted = power_control_r[cssp_pkg::CSSP_PWR_IDL];
  wire logic down = power_control_r[cssp_pkg::CSSP_PWR_PD];
  wire logic cpu_run = !halted && !down;

  cssp_cycle_div u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .six_clk_mode(six_mode_r),
    .run(!down),
    .tick(machine_tick)
  );

  // core op decode: bit vs byte is from the op type only
  wire logic is_bit_op = (core_op == cssp_pkg::CSSP_OP_BITSET) ||
                         (core_op == cssp_pkg::CSSP_OP_BITCLR);
  wire logic ram_bit_ok = core_addr >= cssp_pkg::CSSP_BITRAM_LO &&
                          core_addr <= cssp_pkg::CSSP_BITRAM_HI;
  wire logic sfr_bit_ok = core_addr[7] && core_addr[2:0] == 3'h0;
  wire logic [7:0] sp_inc = stack_top_pointer_r + 8'h01;
  wire logic [7:0] sp_dec = stack_top_pointer_r - 8'h01;
  // done blocks a second take while the requester still holds its op
  wire logic op_go = cpu_run && core_op != cssp_pkg::CSSP_OP_NONE &&
                     op_r == cssp_pkg::CSSP_OP_NONE && !core_done;
  wire logic [7:0] bit_mask = 8'h01 << core_bit;
  wire logic bit_val = core_op == cssp_pkg::CSSP_OP_BITSET;

  // axi decode
  wire logic do_write = aw_held_r && w_held_r && !s_axi_bvalid;
  wire logic [11:0] wa = awaddr_r[13:2];
  wire logic [11:0] ra = s_axi_araddr[13:2];
  wire logic w_ram = wa[11:8] == 4'h4;
  wire logic w_pull = wa == {4'h0, cssp_pkg::CSSP_IDX_PULLUP};
  wire logic w_pwr = wa == {4'h0, cssp_pkg::CSSP_IDX_PWR};
  wire logic w_sp = wa == {4'h0, cssp_pkg::CSSP_IDX_SP};
  wire logic w_flg = wa == {4'h0, cssp_pkg::CSSP_IDX_FLAGS};
  wire logic w_b = wa == {4'h0, cssp_pkg::CSSP_IDX_B};
  wire logic w_serial_control_register = wa == {4'h0, cssp_pkg::CSSP_IDX_SERIAL_CONTROL_REGISTER};
  wire logic w_hit = w_ram || w_pull || w_pwr || w_sp || w_flg || w_b || w_serial_control_register;
  wire logic w_lane = wstrb_r[0];
  wire logic [7:0] wbyte = wdata_r[7:0];
  wire logic [7:0] serial_control_register_view = {serial_control_register_top_r, 7'h00};
  wire logic [7:0] serial_control_register_rd = power_control_r[cssp_pkg::CSSP_PWR_FCS] ?
                             {frame_error_flag, 7'h00} : serial_control_register_view;
  wire logic rd_ram = ra[11:8] == 4'h4;
  wire logic [7:0] rd_byte =
    rd_ram ? ram_r[ra[7:0]] :
    ra == {4'h0, cssp_pkg::CSSP_IDX_PULLUP} ? port0_pullup_ctrl_r :
    ra == {4'h0, cssp_pkg::CSSP_IDX_PWR} ? (power_control_r & cssp_pkg::CSSP_PWR_WMASK) :
    ra == {4'h0, cssp_pkg::CSSP_IDX_SP} ? stack_top_pointer_r :
    ra == {4'h0, cssp_pkg::CSSP_IDX_FLAGS} ? alu_flags_register_r :
    ra == {4'h0, cssp_pkg::CSSP_IDX_B} ? b_reg_r :
    ra == {4'h0, cssp_pkg::CSSP_IDX_SERIAL_CONTROL_REGISTER} ? serial_control_register_rd :
    ra == {4'h0, cssp_pkg::CSSP_IDX_STAT} ? {5'h00, six_mode_r, down, halted} :
    ra == {4'h0, cssp_pkg::CSSP_IDX_CORE} ? op_cnt_r : cssp_pkg::CSSP_BYTE_ZERO;
  wire logic r_hit = rd_ram || ra == {4'h0, cssp_pkg::CSSP_IDX_PULLUP} ||
                     ra == {4'h0, cssp_pkg::CSSP_IDX_PWR} || ra == {4'h0, cssp_pkg::CSSP_IDX_SP} ||
                     ra == {4'h0, cssp_pkg::CSSP_IDX_FLAGS} || ra == {4'h0, cssp_pkg::CSSP_IDX_B} ||
                     ra == {4'h0, cssp_pkg::CSSP_IDX_SERIAL_CONTROL_REGISTER} || ra == {4'h0, cssp_pkg::CSSP_IDX_STAT} ||
                     ra == {4'h0, cssp_pkg::CSSP_IDX_CORE};
  wire logic rd_take = s_axi_arvalid && s_axi_arready;
  wire logic pwr_wr = do_write && w_pwr && w_lane && !op_go && !call_hi_r;

  // synchronisers and strap capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      por_sync_r <= 3'h0;
      wake_sync_r <= 3'h0;
      por_seen_r <= 1'b0;
      strap_caught_r <= 1'b0;
      six_mode_r <= 1'b0;
    end else begin
      por_sync_r <= {por_sync_r[1:0], por_event};
      wake_sync_r <= {wake_sync_r[1:0], wake_event};
      por_seen_r <= por_sync_r[1] && por_sync_r[2];
      strap_caught_r <= 1'b1;
      if (!strap_caught_r) begin
        six_mode_r <= six_clk_strap;
      end
    end
  end

  // power control: software writes, hardware sets por and clears idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_control_r <= cssp_pkg::CSSP_PWR_RESET;
      port0_pullup_ctrl_r <= cssp_pkg::CSSP_BYTE_ZERO;
    end else begin
      if (pwr_wr) begin
        power_control_r <= wbyte & cssp_pkg::CSSP_PWR_WMASK;
      end
      if (do_write && w_pull && w_lane) begin
        port0_pullup_ctrl_r <= {7'h00, wbyte[0]};
      end
      // set wins over a same-cycle software clear
      if (por_pulse) begin
        power_control_r[cssp_pkg::CSSP_PWR_POR] <= 1'b1;
      end
      // only an interrupt ends idle; a synchronised wake event ends power-down
      if (halted && irq_pending && !(pwr_wr && wbyte[cssp_pkg::CSSP_PWR_IDL])) begin
        power_control_r[cssp_pkg::CSSP_PWR_IDL] <= 1'b0;
      end
      if (down && wake_lvl) begin
        power_control_r[cssp_pkg::CSSP_PWR_PD] <= 1'b0;
      end
    end
  end

  // stack, ram and core-side sfrs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stack_top_pointer_r <= cssp_pkg::CSSP_SP_RESET;
      alu_flags_register_r <= cssp_pkg::CSSP_BYTE_ZERO;
      b_reg_r <= cssp_pkg::CSSP_BYTE_ZERO;
      serial_control_register_top_r <= 1'b0;
      op_r <= cssp_pkg::CSSP_OP_NONE;
      call_hi_r <= 1'b0;
      core_rdata <= cssp_pkg::CSSP_BYTE_ZERO;
      core_done <= 1'b0;
      op_cnt_r <= cssp_pkg::CSSP_BYTE_ZERO;
    end else begin
      core_done <= 1'b0;
      if (alu_flags_we && cpu_run) begin
        alu_flags_register_r <= alu_flags_in;
      end
      if (op_go) begin
        op_cnt_r <= op_cnt_r + 8'h01;
        case (core_op)
          cssp_pkg::CSSP_OP_PUSH: begin
            stack_top_pointer_r <= sp_inc;
            ram_r[sp_inc] <= core_wdata;
            core_done <= 1'b1;
          end
          cssp_pkg::CSSP_OP_POP: begin
            core_rdata <= ram_r[stack_top_pointer_r];
            stack_top_pointer_r <= sp_dec;
            core_done <= 1'b1;
          end
          cssp_pkg::CSSP_OP_CALL: begin
            // low byte now, high byte next cycle
            stack_top_pointer_r <= sp_inc;
            ram_r[sp_inc] <= return_addr[7:0];
            op_r <= cssp_pkg::CSSP_OP_CALL;
            call_hi_r <= 1'b1;
          end
          cssp_pkg::CSSP_OP_BITSET, cssp_pkg::CSSP_OP_BITCLR: begin
            if (is_bit_op && ram_bit_ok) begin
              ram_r[core_addr] <= bit_val ? (ram_r[core_addr] | bit_mask) :
                                            (ram_r[core_addr] & ~bit_mask);
            end else if (is_bit_op && sfr_bit_ok && core_addr == cssp_pkg::CSSP_IDX_B) begin
              b_reg_r[core_bit] <= bit_val;
            end else if (is_bit_op && sfr_bit_ok && core_addr == cssp_pkg::CSSP_IDX_FLAGS) begin
              alu_flags_register_r[core_bit] <= bit_val;
            end
            core_done <= 1'b1;
          end
          default: begin
            core_done <= 1'b1;
          end
        endcase
      end else if (call_hi_r) begin
        stack_top_pointer_r <= sp_inc;
        ram_r[sp_inc] <= return_addr[15:8];
        call_hi_r <= 1'b0;
        op_r <= cssp_pkg::CSSP_OP_NONE;
        core_done <= 1'b1;
      end
      if (do_write && w_lane && !op_go && !call_hi_r) begin
        if (w_ram) begin
          ram_r[wa[7:0]] <= wbyte;
        end
        if (w_sp) begin
          stack_top_pointer_r <= wbyte;
        end
        if (w_flg) begin
          alu_flags_register_r <= wbyte;
        end
        if (w_b) begin
          b_reg_r <= wbyte;
        end
        if (w_serial_control_register) begin
          serial_control_register_top_r <= wbyte[7];
        end
      end
    end
  end

  // axi write channel: address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 32'h0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= cssp_pkg::CSSP_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_held_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      // core ops take the ram port first; a write waits one cycle, two during a call
      if (do_write && !op_go && !call_hi_r) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= w_hit ? cssp_pkg::CSSP_RESP_OKAY : cssp_pkg::CSSP_RESP_SLVERR;
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // axi read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= cssp_pkg::CSSP_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h0, rd_byte};
        s_axi_rresp <= r_hit ? cssp_pkg::CSSP_RESP_OKAY : cssp_pkg::CSSP_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // registered outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_clk_en <= 1'b0;
      periph_clk_en <= 1'b0;
      port0_pullup_select <= 1'b0;
      baud_doubler <= 1'b0;
      serial_mode_top_bit <= 1'b0;
      b_operand <= cssp_pkg::CSSP_BYTE_ZERO;
    end else begin
      cpu_clk_en <= cpu_run;
      periph_clk_en <= !down;
      port0_pullup_select <= port0_pullup_ctrl_r[0];
      baud_doubler <= power_control_r[cssp_pkg::CSSP_PWR_BAUD];
      serial_mode_top_bit <= serial_control_register_top_r;
      b_operand <= b_reg_r;
    end
  end
endmodule : cssp_core

// ===== cssp_core_assertions.sv
// checker: timing relations on the ports of cssp_core
`timescale 1ns/1ps
module cssp_core_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [2:0] core_op,
  input wire logic core_done,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [1:0] s_axi_rresp,
  input wire logic machine_tick,
  input wire logic cpu_clk_en,
  input wire logic periph_clk_en
);
  logic [4:0] gap_r;
  logic [4:0] gap_nxt;
  // counts only while clocks run, so power-down never looks like a lost tick
  assign gap_nxt = (machine_tick || !periph_clk_en) ? 5'h00 : gap_r + 5'h01;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_r <= 5'h00;
    end else begin
      gap_r <= gap_nxt;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_tick_space: assert property (machine_tick |=> !machine_tick [*5])
    else $error("machine ticks closer than six clocks");
  chk_tick_bound: assert property (gap_r <= 5'h0C)
    else $error("machine tick missing for over twelve clocks");
  chk_pd_freeze: assert property (!periph_clk_en |-> !machine_tick && !cpu_clk_en)
    else $error("activity while all clocks stopped");
  chk_idle_cpu: assert property (cpu_clk_en |-> periph_clk_en)
    else $error("cpu clock runs without peripheral clock");
  chk_push_done: assert property ($rose(core_op == 3'h1) |-> ##[1:2] core_done)
    else $error("push not completed");
  chk_pop_done: assert property ($rose(core_op == 3'h2) |-> ##[1:2] core_done)
    else $error("pop not completed");
  chk_call_done: assert property ($rose(core_op == 3'h3) |-> ##[2:3] core_done)
    else $error("call push not completed");
  chk_aw_to_b: assert property (s_axi_awready |-> ##[1:4] s_axi_bvalid)
    else $error("write response late");
  chk_ar_to_r: assert property (s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read data late");
  chk_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  cov_push: cover property ($rose(core_op == 3'h1) ##1 core_done);
  cov_pd: cover property (!periph_clk_en && aresetn);
  cov_idle_tick: cover property (!cpu_clk_en && machine_tick);
  cov_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule : cssp_core_assertions

bind cssp_core cssp_core_assertions chk_u (.aclk, .aresetn, .core_op, .core_done,
  .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rresp, .machine_tick, .cpu_clk_en, .periph_clk_en);

// ===== cssp_core_tb.sv
// testbench: registers, stack, bit access and power states of cssp_core
`timescale 1ns/1ps
module cssp_core_tb;
  logic aclk, aresetn, por_event, six_clk_strap, irq_pending, wake_event, alu_flags_we;
  logic frame_error_flag, core_done, machine_tick, cpu_clk_en, periph_clk_en;
  logic port0_pullup_select, baud_doubler, serial_mode_top_bit;
  logic [7:0] alu_flags_in, core_addr, core_wdata, core_rdata, b_operand;
  logic [2:0] core_op, core_bit;
  logic [15:0] return_addr;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int error_cnt = 0;
  int cmp_count = 0;
  cssp_core dut_u (.aclk, .aresetn, .por_event, .six_clk_strap, .irq_pending, .wake_event,
    .alu_flags_in, .alu_flags_we, .frame_error_flag, .core_op, .core_addr, .core_bit,
    .return_addr, .core_wdata, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .core_rdata, .core_done, .machine_tick, .cpu_clk_en, .periph_clk_en,
    .port0_pullup_select, .baud_doubler, .serial_mode_top_bit, .b_operand);
  function automatic logic [31:0] ba(input logic [7:0] i);
    return {22'h000000, i, 2'h0};
  endfunction : ba
  function automatic logic [31:0] ra(input logic [7:0] a);
    return 32'h00001000 + ba(a);
  endfunction : ra
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [7:0] v);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 40);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    chk(n < 40, 1, "write answer");
  endtask : wr
  task automatic rd(input logic [31:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 40);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk(n < 40, 1, "read answer");
  endtask : rd
  task automatic rdc(input logic [31:0] a, input logic [7:0] e, input string m);
    rd(a);
    chk(d, {24'h000000, e}, m);
  endtask : rdc
  task automatic op(input cssp_pkg::cssp_op_type k, input logic [7:0] a, input logic [2:0] b,
                    input logic [7:0] v);
    int n;
    @(posedge aclk);
    core_op <= k;
    core_addr <= a;
    core_bit <= b;
    core_wdata <= v;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (core_done !== 1'b1 && n < 10);
    core_op <= cssp_pkg::CSSP_OP_NONE;
    chk(n < 10, 1, "core op done");
  endtask : op
  task automatic settle();
    repeat (3) @(posedge aclk);
    #1;
  endtask : settle
  task automatic do_reset(input logic strap);
    @(posedge aclk);
    aresetn <= 1'b0;
    six_clk_strap <= strap;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask : do_reset
  task automatic tick_gap(input int e);
    int n;
    n = 0;
    @(posedge aclk);
    while (machine_tick !== 1'b1 && n < 30) begin
      @(posedge aclk);
      n++;
    end
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (machine_tick !== 1'b1 && n < 30);
    chk(n, e, "tick spacing");
  endtask : tick_gap
  task automatic t_regs();
    rdc(ba(cssp_pkg::CSSP_IDX_SP), 8'h07, "sp reset");
    rdc(ba(cssp_pkg::CSSP_IDX_PWR), 8'h10, "pwr reset");
    wr(ba(cssp_pkg::CSSP_IDX_PWR), 8'hEC);
    rdc(ba(cssp_pkg::CSSP_IDX_PWR), 8'hCC, "user flags");
    settle();
    chk(baud_doubler, 1, "baud on");
    wr(ba(cssp_pkg::CSSP_IDX_PWR), 8'h00);
    settle();
    chk(baud_doubler, 0, "baud off");
    @(posedge aclk);
    por_event <= 1'b1;
    repeat (8) @(posedge aclk);
    rdc(ba(cssp_pkg::CSSP_IDX_PWR), 8'h10, "power-on flag set");
    por_event <= 1'b0;
    wr(ba(cssp_pkg::CSSP_IDX_PWR), 8'h00);
    rdc(ba(cssp_pkg::CSSP_IDX_PWR), 8'h00, "power-on flag cleared");
    for (int i = 1; i >= 0; i--) begin
      wr(ba(cssp_pkg::CSSP_IDX_PULLUP), 8'(i));
      settle();
      chk(port0_pullup_select, 32'(i), "pull-up select");
    end
    rd(ba(8'hFF));
    chk(d, 32'h0, "unmapped read data");
    chk(32'(r), 32'(cssp_pkg::CSSP_RESP_SLVERR), "unmapped read");
    wr(ba(8'hFF), 8'h55);
    chk(r, cssp_pkg::CSSP_RESP_SLVERR, "unmapped write");
    $display("done registers");
  endtask : t_regs
  task automatic t_serial();
    @(posedge aclk);
    frame_error_flag <= 1'b1;
    wr(ba(cssp_pkg::CSSP_IDX_SERIAL_CONTROL_REGISTER), 8'h00);
    wr(ba(cssp_pkg::CSSP_IDX_PWR), 8'h40);
    rdc(ba(cssp_pkg::CSSP_IDX_SERIAL_CONTROL_REGISTER), 8'h80, "frame error shown");
    @(posedge aclk);
    frame_error_flag <= 1'b0;
    rdc(ba(cssp_pkg::CSSP_IDX_SERIAL_CONTROL_REGISTER), 8'h00, "frame error clear");
    @(posedge aclk);
    frame_error_flag <= 1'b1;
    wr(ba(cssp_pkg::CSSP_IDX_PWR), 8'h00);
    rdc(ba(cssp_pkg::CSSP_IDX_SERIAL_CONTROL_REGISTER), 8'h00, "mode bit used");
    wr(ba(cssp_pkg::CSSP_IDX_SERIAL_CONTROL_REGISTER), 8'h80);
    settle();
    chk(serial_mode_top_bit, 1, "mode bit out");
    $display("done serial");
  endtask : t_serial
  task automatic t_stack();
    wr(ra(8'hFF), 8'h3C);
    rdc(ra(8'hFF), 8'h3C, "top ram byte");
    wr(ba(cssp_pkg::CSSP_IDX_SP), 8'h30);
    op(cssp_pkg::CSSP_OP_PUSH, 8'h00, 3'h0, 8'hA5);
    rdc(ba(cssp_pkg::CSSP_IDX_SP), 8'h31, "sp after push");
    rdc(ra(8'h31), 8'hA5, "pushed byte");
    op(cssp_pkg::CSSP_OP_POP, 8'h00, 3'h0, 8'h00);
    chk(core_rdata, 8'hA5, "popped byte");
    rdc(ba(cssp_pkg::CSSP_IDX_SP), 8'h30, "sp after pop");
    return_addr <= 16'h1234;
    op(cssp_pkg::CSSP_OP_CALL, 8'h00, 3'h0, 8'h00);
    rdc(ba(cssp_pkg::CSSP_IDX_SP), 8'h32, "sp after call");
    rdc(ra(8'h31), 8'h34, "return low");
    rdc(ra(8'h32), 8'h12, "return high");
    $display("done stack");
  endtask : t_stack
  task automatic t_bits();
    wr(ra(8'h20), 8'h00);
    op(cssp_pkg::CSSP_OP_BITSET, 8'h20, 3'h3, 8'h00);
    rdc(ra(8'h20), 8'h08, "bit set low edge");
    wr(ra(8'h2F), 8'hFF);
    op(cssp_pkg::CSSP_OP_BITCLR, 8'h2F, 3'h7, 8'h00);
    rdc(ra(8'h2F), 8'h7F, "bit clear high edge");
    wr(ba(cssp_pkg::CSSP_IDX_B), 8'h5A);
    settle();
    chk(b_operand, 8'h5A, "b register");
    op(cssp_pkg::CSSP_OP_BITSET, cssp_pkg::CSSP_IDX_B, 3'h0, 8'h00);
    settle();
    chk(b_operand, 8'h5B, "sfr bit set");
    @(posedge aclk);
    alu_flags_in <= 8'hC5;
    alu_flags_we <= 1'b1;
    @(posedge aclk);
    alu_flags_we <= 1'b0;
    rdc(ba(cssp_pkg::CSSP_IDX_FLAGS), 8'hC5, "alu flags");
    $display("done bits");
  endtask : t_bits
  task automatic t_power();
    int n;
    wr(ba(cssp_pkg::CSSP_IDX_PWR), 8'h01);
    settle();
    chk({cpu_clk_en, periph_clk_en}, 2'b01, "idle clocks");
    tick_gap(12);
    @(posedge aclk);
    irq_pending <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (cpu_clk_en !== 1'b1 && n < 20);
    irq_pending <= 1'b0;
    rdc(ba(cssp_pkg::CSSP_IDX_PWR), 8'h00, "idle bit cleared");
    wr(ba(cssp_pkg::CSSP_IDX_PWR), 8'h02);
    settle();
    chk({cpu_clk_en, periph_clk_en}, 2'b00, "power-down clocks");
    n = 0;
    repeat (40) begin
      @(posedge aclk);
      if (machine_tick !== 1'b0) n++;
    end
    chk(n, 0, "ticks in power-down");
    wake_event <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (periph_clk_en !== 1'b1 && n < 20);
    wake_event <= 1'b0;
    rdc(ba(cssp_pkg::CSSP_IDX_PWR), 8'h00, "power-down left");
    $display("done power");
  endtask : t_power
  task automatic t_cycle();
    tick_gap(12);
    do_reset(1'b1);
    tick_gap(6);
    rdc(ba(cssp_pkg::CSSP_IDX_STAT), 8'h04, "six clock status");
    do_reset(1'b0);
    $display("done machine cycle");
  endtask : t_cycle
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  initial begin
    {aresetn, por_event, six_clk_strap, irq_pending, wake_event, alu_flags_we} = 6'h00;
    {frame_error_flag, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, core_op, core_bit} = 8'h00;
    {alu_flags_in, core_addr, core_wdata, return_addr} = 40'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'h1;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_serial();
    t_stack();
    t_bits();
    t_power();
    t_cycle();
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    give_verdict();
  end
endmodule : cssp_core_tb
